// ---- rbv_regs.vh ----
`ifndef RBV_REGS_VH
`define RBV_REGS_VH

// ==========================================================
// register offsets (word index on the plain port)
`define RBV_OFS_CTRL        4'h0
`define RBV_OFS_STATUS      4'h1
`define RBV_OFS_RTPARAM     4'h2
`define RBV_OFS_COUNTS      4'h3

// ==========================================================
// field positions
`define RBV_CTRL_RD13_BIT   0
`define RBV_ST_FLAG2_LSB    0
`define RBV_ST_FLAG1_LSB    8
`define RBV_ST_BUSY_BIT     16
`define RBV_ST_MODE_LSB     17
`define RBV_RT_READ_LSB     0
`define RBV_RT_WRITE_LSB    8
`define RBV_CNT_OK_LSB      0
`define RBV_CNT_ERR_LSB     8

// ==========================================================
// reset values
`define RBV_CTRL_RST        1'b0
`define RBV_RT_RST          8'h00

// ==========================================================
// status flag codes
`define RBV_FLAG_OK         8'h00
`define RBV_FLAG_ERR        8'hFF
`define RBV_FLAG2_SVC_CNT   8'hA1
`define RBV_FLAG2_BLK_CNT   8'hA2
`define RBV_FLAG2_SVC_MIS   8'hA3
`define RBV_FLAG2_BLK_SPEC  8'hA5

// ==========================================================
// limits
`define RBV_SVC_MAX_READ    5'h0F
`define RBV_SVC_MAX_WRITE   5'h0B
`define RBV_SVC_WR_SMALL    5'h08
`define RBV_BLK_MAX_READ    5'h0F
`define RBV_BLK_MAX_RD_ALT  5'h0D
`define RBV_BLK_MAX_WR_LO   5'h0C
`define RBV_BLK_MAX_WR_HI   5'h0B
`define RBV_ENC_PARAM_BLKS  5'h02
`define RBV_ENC_MIN_BLKS    5'h03
`define RBV_LAST_BLOCK_NO   8'h1F
`define RBV_LIST_DEPTH      16

// ==========================================================
// block roles
`define RBV_ROLE_DATA       2'h0
`define RBV_ROLE_IV         2'h1
`define RBV_ROLE_MAC        2'h2

`endif

// ---- rbv_block_list_validator.v ----
// How it works
// - read and write response-time bytes are loaded from nonvolatile settings
// - identification answer always goes out in slot zero
// - read takes up to 15 services, write up to 11
// - all listed services must carry the same service file value
// - blocks are 16 bytes, chosen by two- or three-byte elements
// - access-mode bits 6..4 of element byte 0 nonzero gives error
// - bits 7..3 of third element byte nonzero gives error
// - third byte bit 2 selects tunnel, bits 1..0 select encryption
// - encryption code 01 is reserved and gives error
// - read block limit 15, or 13 for RF plaintext when selected
// - write takes 12 blocks with 1..8 services, 11 with 9..11
// - encrypted lists spend two blocks on parameters
// - RF plaintext accepts any block order and touches every block
// - tunnel plaintext requires ascending block numbers
// - encrypted touches entries 0..m-3 only and requires ascending order
// - all blocks must share one communication and encryption mode
// - 0xFF followed by 0x00 still counts as ascending
// - encrypted data is IV, payload, then MAC; plaintext is all payload
// - element errors answer FF/A5
// - service mismatch answers FF/A3, service count FF/A1
// - block count answers FF/A2, success answers 00/00
`timescale 1ns/100ps
`include "rbv_regs.vh"

module rbv_block_list_validator
(
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rstn,
  // register port
  input  wire [3:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  // nonvolatile settings
  input  wire        i_nv_load,
  input  wire [7:0]  i_nv_rt_read,
  input  wire [7:0]  i_nv_rt_write,
  output reg  [7:0]  o_rt_read,
  output reg  [7:0]  o_rt_write,
  // identification request
  input  wire        i_req_valid,
  output reg         o_id_valid,
  output reg  [7:0]  o_id_slot,
  // command parameters
  input  wire        i_cmd_start,
  input  wire        i_cmd_write,
  input  wire        i_svc_valid,
  input  wire [15:0] i_svc_code,
  input  wire        i_elem_valid,
  input  wire        i_elem_three,
  input  wire [7:0]  i_elem_d0,
  input  wire [7:0]  i_elem_d1,
  input  wire [7:0]  i_elem_d2,
  input  wire        i_cmd_end,
  // result
  output wire        o_busy,
  output reg         o_done,
  output reg  [7:0]  o_status1,
  output reg  [7:0]  o_status2,
  output reg         o_tunnel,
  output reg  [1:0]  o_enc_mode,
  // block access stream
  output reg         o_acc_valid,
  output reg  [7:0]  o_acc_blk,
  output reg         o_acc_touch,
  output reg  [1:0]  o_acc_role
);

  // ==========================================================
  // states
  localparam [2:0] ST_IDLE    = 3'd0;
  localparam [2:0] ST_COLLECT = 3'd1;
  localparam [2:0] ST_CHECK   = 3'd2;
  localparam [2:0] ST_ACCESS  = 3'd3;
  localparam [2:0] ST_DONE    = 3'd4;

  // ==========================================================
  // helpers
  // strictly rising, with the single wrap from the top value to zero allowed
  function asc_ok;
    input [7:0] prev;
    input [7:0] nxt;
    begin
      asc_ok = (nxt > prev) || ((prev == 8'hFF) && (nxt == 8'h00));
    end
  endfunction

  function [4:0] blk_limit;
    input       is_wr;
    input [4:0] svc_n;
    input       rd13;
    input       rf_plain;
    begin
      if (is_wr)
        blk_limit = (svc_n <= `RBV_SVC_WR_SMALL) ? `RBV_BLK_MAX_WR_LO
                                                 : `RBV_BLK_MAX_WR_HI;
      else if (rd13 && rf_plain)
        blk_limit = `RBV_BLK_MAX_RD_ALT;
      else
        blk_limit = `RBV_BLK_MAX_READ;
    end
  endfunction

  // ==========================================================
  // state
  reg  [2:0]  state_reg;
  reg         is_wr_reg;
  reg         rd13_reg;
  reg  [4:0]  svc_cnt_reg;
  reg  [15:0] svc_first_reg;
  reg         svc_mis_reg;
  reg  [4:0]  blk_cnt_reg;
  reg  [7:0]  last_blk_reg;
  reg  [2:0]  mode_reg;
  reg         mode_mis_reg;
  reg         elem_err_reg;
  reg         order_bad_reg;
  reg  [15:0] oor_reg;
  reg  [3:0]  idx_reg;
  reg  [7:0]  ok_cnt_reg;
  reg  [7:0]  err_cnt_reg;
  reg  [7:0]  blk_mem [0:`RBV_LIST_DEPTH-1];

  wire [2:0]  elem_mode = i_elem_three ? i_elem_d2[2:0] : 3'b000;
  wire        enc       = mode_reg[1];
  wire        tunnel    = mode_reg[2];
  wire        rf_plain  = ~enc & ~tunnel;
  wire [4:0]  svc_max   = is_wr_reg ? `RBV_SVC_MAX_WRITE : `RBV_SVC_MAX_READ;
  wire [4:0]  lim       = blk_limit(is_wr_reg, svc_cnt_reg, rd13_reg, rf_plain);
  wire [4:0]  touch_n   = enc ? (blk_cnt_reg - `RBV_ENC_PARAM_BLKS) : blk_cnt_reg;
  wire [4:0]  last_idx  = blk_cnt_reg - 5'd1;

  assign o_busy = (state_reg != ST_IDLE);

  // ==========================================================
  // only touched entries of non-tunnel lists are held to the memory range
  reg         oor_touched;
  integer     k;
  always @*
  begin
    oor_touched = 1'b0;
    for (k = 0; k < `RBV_LIST_DEPTH; k = k + 1)
      if (oor_reg[k] && (k[4:0] < touch_n))
        oor_touched = 1'b1;
  end

  // ==========================================================
  // final verdict, in priority order
  reg  [7:0]  verdict2;
  always @*
  begin
    if ((svc_cnt_reg == 5'd0) || (svc_cnt_reg > svc_max))
      verdict2 = `RBV_FLAG2_SVC_CNT;
    else if (svc_mis_reg)
      verdict2 = `RBV_FLAG2_SVC_MIS;
    else if ((blk_cnt_reg == 5'd0) || (blk_cnt_reg > lim) ||
             (enc && (blk_cnt_reg < `RBV_ENC_MIN_BLKS)))
      verdict2 = `RBV_FLAG2_BLK_CNT;
    else if (elem_err_reg || mode_mis_reg || (order_bad_reg && !rf_plain) ||
             (oor_touched && !tunnel))
      verdict2 = `RBV_FLAG2_BLK_SPEC;
    else
      verdict2 = `RBV_FLAG_OK;
  end

  // ==========================================================
  // control registers and nonvolatile bytes
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rd13_reg   <= `RBV_CTRL_RST;
      o_rt_read  <= `RBV_RT_RST;
      o_rt_write <= `RBV_RT_RST;
      o_id_valid <= 1'b0;
      o_id_slot  <= 8'h00;
    end
    else
    begin
      if (i_wr && (i_addr == `RBV_OFS_CTRL))
        rd13_reg <= i_wdata[`RBV_CTRL_RD13_BIT];
      if (i_nv_load)
      begin
        o_rt_read  <= i_nv_rt_read;
        o_rt_write <= i_nv_rt_write;
      end
      // whatever slot count is asked, answer in the first one
      o_id_valid <= i_req_valid;
      o_id_slot  <= 8'h00;
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= 32'h0000_0000;
    else if (i_rd)
    begin
      o_rdata <= 32'h0000_0000;
      case (i_addr)
        `RBV_OFS_CTRL:
          o_rdata[`RBV_CTRL_RD13_BIT] <= rd13_reg;
        `RBV_OFS_STATUS:
        begin
          o_rdata[`RBV_ST_FLAG2_LSB +: 8] <= o_status2;
          o_rdata[`RBV_ST_FLAG1_LSB +: 8] <= o_status1;
          o_rdata[`RBV_ST_BUSY_BIT]       <= o_busy;
          o_rdata[`RBV_ST_MODE_LSB +: 3]  <= {o_tunnel, o_enc_mode};
        end
        `RBV_OFS_RTPARAM:
        begin
          o_rdata[`RBV_RT_READ_LSB +: 8]  <= o_rt_read;
          o_rdata[`RBV_RT_WRITE_LSB +: 8] <= o_rt_write;
        end
        `RBV_OFS_COUNTS:
        begin
          o_rdata[`RBV_CNT_OK_LSB +: 8]  <= ok_cnt_reg;
          o_rdata[`RBV_CNT_ERR_LSB +: 8] <= err_cnt_reg;
        end
        default:
          o_rdata <= 32'h0000_0000;
      endcase
    end
    else
      o_rdata <= 32'h0000_0000;
  end

  // ==========================================================
  // block list store; no reset needed, entries are written before use
  always @(posedge i_clk)
  begin
    if ((state_reg == ST_COLLECT) && i_elem_valid && !blk_cnt_reg[4])
      blk_mem[blk_cnt_reg[3:0]] <= i_elem_d1;
  end

  // ==========================================================
  // command sequencer
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_reg     <= ST_IDLE;
      is_wr_reg     <= 1'b0;
      svc_cnt_reg   <= 5'd0;
      svc_first_reg <= 16'h0000;
      svc_mis_reg   <= 1'b0;
      blk_cnt_reg   <= 5'd0;
      last_blk_reg  <= 8'h00;
      mode_reg      <= 3'b000;
      mode_mis_reg  <= 1'b0;
      elem_err_reg  <= 1'b0;
      order_bad_reg <= 1'b0;
      oor_reg       <= 16'h0000;
      idx_reg       <= 4'h0;
      ok_cnt_reg    <= 8'h00;
      err_cnt_reg   <= 8'h00;
      o_done        <= 1'b0;
      o_status1     <= `RBV_FLAG_OK;
      o_status2     <= `RBV_FLAG_OK;
      o_tunnel      <= 1'b0;
      o_enc_mode    <= 2'b00;
      o_acc_valid   <= 1'b0;
      o_acc_blk     <= 8'h00;
      o_acc_touch   <= 1'b0;
      o_acc_role    <= `RBV_ROLE_DATA;
    end
    else
    begin
      o_done      <= 1'b0;
      o_acc_valid <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (i_cmd_start)
          begin
            state_reg     <= ST_COLLECT;
            is_wr_reg     <= i_cmd_write;
            svc_cnt_reg   <= 5'd0;
            svc_mis_reg   <= 1'b0;
            blk_cnt_reg   <= 5'd0;
            mode_mis_reg  <= 1'b0;
            elem_err_reg  <= 1'b0;
            order_bad_reg <= 1'b0;
            oor_reg       <= 16'h0000;
          end
        end
        ST_COLLECT:
        begin
          if (i_svc_valid)
          begin
            if (svc_cnt_reg != 5'h1F)
              svc_cnt_reg <= svc_cnt_reg + 5'd1;
            if (svc_cnt_reg == 5'd0)
              svc_first_reg <= i_svc_code;
            else if (i_svc_code != svc_first_reg)
              svc_mis_reg <= 1'b1;
          end
          if (i_elem_valid)
          begin
            if (blk_cnt_reg != 5'h1F)
              blk_cnt_reg <= blk_cnt_reg + 5'd1;
            if ((i_elem_d0[6:4] != 3'b000) ||
                (i_elem_three && (i_elem_d2[7:3] != 5'b00000)) ||
                (elem_mode[1:0] == 2'b01))
              elem_err_reg <= 1'b1;
            if (blk_cnt_reg == 5'd0)
              mode_reg <= elem_mode;
            else
            begin
              if (elem_mode != mode_reg)
                mode_mis_reg <= 1'b1;
              // order is noted always but only enforced off RF plaintext
              if (!asc_ok(last_blk_reg, i_elem_d1))
                order_bad_reg <= 1'b1;
            end
            last_blk_reg <= i_elem_d1;
            if (!blk_cnt_reg[4] && (i_elem_d1 > `RBV_LAST_BLOCK_NO))
              oor_reg[blk_cnt_reg[3:0]] <= 1'b1;
          end
          if (i_cmd_end)
            state_reg <= ST_CHECK;
        end
        ST_CHECK:
        begin
          // nothing is touched until the verdict is known
          o_status2  <= verdict2;
          o_status1  <= (verdict2 == `RBV_FLAG_OK) ? `RBV_FLAG_OK : `RBV_FLAG_ERR;
          o_tunnel   <= tunnel;
          o_enc_mode <= mode_reg[1:0];
          idx_reg    <= 4'h0;
          if (verdict2 == `RBV_FLAG_OK)
            state_reg <= ST_ACCESS;
          else
          begin
            state_reg   <= ST_DONE;
            err_cnt_reg <= err_cnt_reg + 8'h01;
          end
        end
        ST_ACCESS:
        begin
          o_acc_valid <= 1'b1;
          o_acc_blk   <= blk_mem[idx_reg];
          // trailing two entries of an encrypted list are dummies
          o_acc_touch <= ({1'b0, idx_reg} < touch_n);
          if (enc && (idx_reg == 4'h0))
            o_acc_role <= `RBV_ROLE_IV;
          else if (enc && ({1'b0, idx_reg} == last_idx))
            o_acc_role <= `RBV_ROLE_MAC;
          else
            o_acc_role <= `RBV_ROLE_DATA;
          idx_reg <= idx_reg + 4'h1;
          if ({1'b0, idx_reg} == last_idx)
          begin
            state_reg  <= ST_DONE;
            ok_cnt_reg <= ok_cnt_reg + 8'h01;
          end
        end
        ST_DONE:
        begin
          o_done    <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // rbv_block_list_validator

// ---- rbv_validator_asserts.sv ----
`timescale 1ns/100ps
// ==========================================================
// port checks for the block-list validator
module rbv_validator_asserts
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // stimulus side
  input  wire logic        i_rd,
  input  wire logic        i_req_valid,
  input  wire logic        i_nv_load,
  input  wire logic [7:0]  i_nv_rt_read,
  input  wire logic [7:0]  i_nv_rt_write,
  input  wire logic        i_cmd_end,
  // design outputs
  input  wire logic [31:0] o_rdata,
  input  wire logic [7:0]  o_rt_read,
  input  wire logic [7:0]  o_rt_write,
  input  wire logic        o_id_valid,
  input  wire logic [7:0]  o_id_slot,
  input  wire logic        o_busy,
  input  wire logic        o_done,
  input  wire logic [7:0]  o_status1,
  input  wire logic [7:0]  o_status2,
  input  wire logic [1:0]  o_enc_mode,
  input  wire logic        o_acc_valid,
  input  wire logic        o_acc_touch,
  input  wire logic [1:0]  o_acc_role
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_rt_load : assert property (
    i_nv_load |=> o_rt_read == $past(i_nv_rt_read) && o_rt_write == $past(i_nv_rt_write))
    else $error("response time bytes not loaded");
  a_id_slot : assert property (
    i_req_valid |=> o_id_valid && o_id_slot == 8'h00)
    else $error("identification not in first slot");
  a_status_code : assert property (
    o_done |-> {o_status1, o_status2} inside {16'h0000, 16'hffa1, 16'hffa2, 16'hffa3, 16'hffa5})
    else $error("status pair not a known code");
  a_no_err_access : assert property (
    o_acc_valid |-> o_status1 == 8'h00 && o_status2 == 8'h00)
    else $error("block accessed on rejected command");
  a_check_first : assert property (
    i_cmd_end && o_busy |-> ##3 (o_done || o_acc_valid))
    else $error("check did not end three cycles after list end");
  a_done_after : assert property (
    o_acc_valid ##1 !o_acc_valid |-> o_done)
    else $error("done not right after last access");
  a_plain_all : assert property (
    o_acc_valid && o_enc_mode == 2'h0 |-> o_acc_touch && o_acc_role == 2'h0)
    else $error("plaintext entry skipped or not data");
  a_iv_first : assert property (
    o_acc_valid && !$past(o_acc_valid) && o_enc_mode[1] |-> o_acc_role == 2'h1 && o_acc_touch)
    else $error("encrypted list not led by iv");
  a_mac_last : assert property (
    o_acc_valid && o_enc_mode[1] && o_acc_role == 2'h2 |-> !o_acc_touch ##1 o_done)
    else $error("mac entry touched or not last");
  a_rdata_idle : assert property (
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  // busy must cover the closing cycle and drop as done is shown
  a_busy_span : assert property (
    o_done |-> !o_busy && $past(o_busy))
    else $error("busy not framing the command");
endmodule // rbv_validator_asserts

bind rbv_block_list_validator rbv_validator_asserts u_asserts (.*);

// ---- rbv_reader_model.sv ----
`timescale 1ns/100ps
// ==========================================================
// reader side: frames one command list and collects accesses
module rbv_reader_model
(
  // clock
  input  wire logic       i_clk,
  // from the validator
  input  wire logic       i_done,
  input  wire logic       i_acc_valid,
  input  wire logic [7:0] i_acc_blk,
  input  wire logic       i_acc_touch,
  input  wire logic [1:0] i_acc_role,
  input  wire logic [7:0] i_rt_rd,
  input  wire logic [7:0] i_rt_wr,
  // to the validator
  output logic            o_start,
  output logic            o_write,
  output logic            o_svc_valid,
  output logic [15:0]     o_svc_code,
  output logic            o_elem_valid,
  output logic            o_three,
  output logic [7:0]      o_d0,
  output logic [7:0]      o_d1,
  output logic [7:0]      o_d2,
  output logic            o_end
);
  logic [7:0] blk [0:15];
  logic       touch [0:15];
  logic [1:0] role [0:15];
  int         nacc;

  initial
  begin
    {o_start, o_write, o_svc_valid, o_svc_code, o_elem_valid} = '0;
    {o_three, o_d0, o_d1, o_d2, o_end} = '0;
  end

  task automatic run(input logic w, input int ns, input logic mis, input int n,
                     input logic th, input logic [7:0] d0, d2, b0, st, input logic mix);
    int k;
    int c;
    int lim;
    logic [7:0] rt;
    logic got;
    c = (ns > n) ? ns : n;
    if (c == 0)
      c = 1;
    rt = w ? i_rt_wr : i_rt_rd;
    lim = (((rt[5:3] + 1) * n + rt[2:0] + 1) << (2 * rt[7:6])) + 64;
    @(posedge i_clk);
    o_start <= 1'b1;
    o_write <= w;
    for (k = 0; k < c; k++)
    begin
      @(posedge i_clk);
      o_start <= 1'b0;
      o_svc_valid <= (k < ns);
      o_svc_code <= (mis && k == ns - 1) ? 16'h0b01 : 16'h0b00;
      o_elem_valid <= (k < n);
      o_three <= th;
      o_d0 <= d0;
      o_d1 <= b0 + 8'(st * k);
      o_d2 <= (mix && k == n - 1) ? d2 ^ 8'h04 : d2;
      o_end <= (k == c - 1);
    end
    @(posedge i_clk);
    // released lines must not keep the last value, or a stale read passes
    {o_svc_valid, o_elem_valid, o_end} <= 3'b000;
    {o_svc_code, o_three, o_d0, o_d1, o_d2} <= ~{o_svc_code, o_three, o_d0, o_d1, o_d2};
    nacc = 0;
    got = 1'b0;
    for (k = 0; k < lim && !got; k++)
    begin
      @(posedge i_clk);
      if (i_acc_valid && nacc < 16)
      begin
        blk[nacc] = i_acc_blk;
        touch[nacc] = i_acc_touch;
        role[nacc] = i_acc_role;
        nacc++;
      end
      got = i_done;
    end
  endtask
endmodule // rbv_reader_model

// ---- rbv_block_list_validator_tb.sv ----
`timescale 1ns/100ps
// ==========================================================
// testbench
module rbv_block_list_validator_tb;
  logic        i_clk, i_rstn, i_wr, i_rd, i_nv_load, i_req_valid;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata;
  logic [7:0]  i_nv_rt_read, i_nv_rt_write, nok, nbad;
  wire  [31:0] o_rdata;
  wire  [15:0] i_svc_code;
  wire  [7:0]  o_rt_read, o_rt_write, o_id_slot, o_status1, o_status2, o_acc_blk;
  wire  [7:0]  i_elem_d0, i_elem_d1, i_elem_d2;
  wire  [1:0]  o_enc_mode, o_acc_role;
  wire         o_id_valid, o_busy, o_done, o_tunnel, o_acc_valid, o_acc_touch;
  wire         i_cmd_start, i_cmd_write, i_svc_valid, i_elem_valid, i_elem_three, i_cmd_end;
  int          mismatches, total_checks, cycles;

  rbv_block_list_validator dut (.*);
  rbv_reader_model u_rdr (.i_clk(i_clk), .i_done(o_done), .i_acc_valid(o_acc_valid),
    .i_acc_blk(o_acc_blk), .i_acc_touch(o_acc_touch), .i_acc_role(o_acc_role),
    .i_rt_rd(o_rt_read), .i_rt_wr(o_rt_write), .o_start(i_cmd_start), .o_write(i_cmd_write),
    .o_svc_valid(i_svc_valid), .o_svc_code(i_svc_code), .o_elem_valid(i_elem_valid),
    .o_three(i_elem_three), .o_d0(i_elem_d0), .o_d1(i_elem_d1), .o_d2(i_elem_d2),
    .o_end(i_cmd_end));

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      mismatches++;
      test_done;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask

  // one command through the reader, then status, mode and every access
  task automatic cmd(input logic w, input int ns, input logic mis, input int n,
                     input logic th, input logic [7:0] d0, d2, b0, st, input logic mix,
                     input logic [7:0] e2);
    int k;
    logic en;
    en = th && d2[1];
    u_rdr.run(w, ns, mis, n, th, d0, d2, b0, st, mix);
    chk({o_status1, o_status2}, {(e2 == 8'h00) ? 8'h00 : 8'hff, e2});
    chk(u_rdr.nacc, (e2 == 8'h00) ? n : 0);
    if (e2 == 8'h00)
      nok++;
    else
      nbad++;
    if (e2 == 8'h00)
    begin
      chk({o_tunnel, o_enc_mode}, th ? d2[2:0] : 3'h0);
      for (k = 0; k < n; k++)
        chk({u_rdr.blk[k], u_rdr.touch[k], u_rdr.role[k]}, {8'(b0 + st * k), !en || k < n - 2,
            en ? (k == 0 ? 2'h1 : (k == n - 1 ? 2'h2 : 2'h0)) : 2'h0});
    end
  endtask

  initial
  begin
    {i_rstn, i_wr, i_rd, i_nv_load, i_req_valid, i_addr, i_wdata} = '0;
    {i_nv_rt_read, i_nv_rt_write, nok, nbad} = '0;
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(4'h0, 32'h0000_0000);
    rd(4'h2, 32'h0000_0000);
    wr(4'h7, 32'hffff_ffff);
    rd(4'h7, 32'h0000_0000);
    @(posedge i_clk);
    i_nv_load <= 1'b1;
    i_nv_rt_read <= 8'h4a;
    i_nv_rt_write <= 8'h13;
    @(posedge i_clk);
    i_nv_load <= 1'b0;
    i_req_valid <= 1'b1;
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    #1 chk({o_id_valid, o_id_slot}, 32'h0000_0100);
    rd(4'h2, 32'h0000_134a);
    cmd(0, 1, 0, 1, 0, 0, 0, 5, 1, 0, 8'h00);
    cmd(0, 16, 0, 1, 0, 0, 0, 5, 1, 0, 8'ha1);
    cmd(1, 12, 0, 1, 0, 0, 0, 5, 1, 0, 8'ha1);
    cmd(0, 15, 0, 15, 0, 0, 0, 8'h1f, 8'hff, 0, 8'h00);
    cmd(0, 3, 1, 1, 0, 0, 0, 5, 1, 0, 8'ha3);
    cmd(0, 1, 0, 16, 0, 0, 0, 0, 1, 0, 8'ha2);
    cmd(1, 8, 0, 12, 0, 0, 0, 0, 1, 0, 8'h00);
    cmd(1, 9, 0, 12, 0, 0, 0, 0, 1, 0, 8'ha2);
    cmd(1, 11, 0, 11, 0, 0, 0, 0, 1, 0, 8'h00);
    cmd(1, 1, 0, 0, 0, 0, 0, 0, 1, 0, 8'ha2);
    cmd(0, 1, 0, 2, 0, 8'h10, 0, 0, 1, 0, 8'ha5);
    cmd(0, 1, 0, 2, 1, 0, 8'h08, 0, 1, 0, 8'ha5);
    cmd(0, 1, 0, 2, 1, 0, 8'h01, 0, 1, 0, 8'ha5);
    cmd(0, 1, 0, 2, 1, 0, 8'h05, 0, 1, 0, 8'ha5);
    cmd(0, 1, 0, 3, 1, 0, 8'h04, 8'h50, 8'hff, 0, 8'ha5);
    cmd(0, 1, 0, 3, 1, 0, 8'h04, 8'hfe, 1, 0, 8'h00);
    cmd(0, 1, 0, 4, 1, 0, 8'h02, 3, 1, 0, 8'h00);
    cmd(1, 1, 0, 5, 1, 0, 8'h07, 8'hfe, 1, 0, 8'h00);
    rd(4'h1, 32'h000e_0000);
    cmd(0, 1, 0, 4, 1, 0, 8'h03, 9, 8'hff, 0, 8'ha5);
    cmd(0, 1, 0, 2, 1, 0, 8'h02, 1, 1, 0, 8'ha2);
    cmd(1, 1, 0, 12, 1, 0, 8'h06, 0, 1, 0, 8'h00);
    cmd(0, 1, 0, 3, 1, 0, 8'h00, 1, 1, 1, 8'ha5);
    cmd(0, 1, 0, 1, 0, 0, 0, 8'h20, 1, 0, 8'ha5);
    wr(4'h0, 32'h0000_0001);
    rd(4'h0, 32'h0000_0001);
    cmd(0, 1, 0, 14, 0, 0, 0, 0, 1, 0, 8'ha2);
    cmd(0, 1, 0, 13, 0, 0, 0, 0, 1, 0, 8'h00);
    cmd(0, 1, 0, 15, 1, 0, 8'h04, 0, 1, 0, 8'h00);
    wr(4'h0, 32'h0000_0000);
    rd(4'h3, {16'h0000, nbad, nok});
    test_done;
  end
endmodule // rbv_block_list_validator_tb
